// [pkg/dtm_map.vh]
`ifndef DTM_MAP_VH
`define DTM_MAP_VH

// Register byte offsets on the AHB-Lite bus
`define DTM_OFF_MODE        8'h00
`define DTM_OFF_CTRL        8'h04
`define DTM_OFF_EXTCFG      8'h08
`define DTM_OFF_CLKCTL      8'h0c
`define DTM_OFF_CNT0        8'h10
`define DTM_OFF_CNT1        8'h14

// Field positions of timer_mode_config
`define DTM_T0_MODE_LO      0
`define DTM_T0_MODE_HI      1
`define DTM_T0_SRC          2
`define DTM_T0_GATE         3
`define DTM_T1_MODE_LO      4
`define DTM_T1_MODE_HI      5
`define DTM_T1_SRC          6
`define DTM_T1_GATE         7

// Field positions of the run and overflow register
`define DTM_T0_RUN          4
`define DTM_T0_OVF          5
`define DTM_T1_RUN          6
`define DTM_T1_OVF          7

// Field positions of ext_irq_cfg_reg
`define DTM_PIN_A_POL       0
`define DTM_PIN_B_POL       1

// Field positions of clock_ctl_reg
`define DTM_T0_PRESC        3
`define DTM_T1_PRESC        4

// Mode encodings
`define DTM_MODE_13BIT      2'h0
`define DTM_MODE_16BIT      2'h1
`define DTM_MODE_8BIT       2'h2
`define DTM_MODE_3          2'h3

// Reset values
`define DTM_RST_MODE        8'h00
`define DTM_RST_POL         2'h0
`define DTM_RST_PRESC       2'h0
`define DTM_RST_CNT         16'h0000

// Prescaled clock divide ratio in system clocks
`define DTM_PRESCALE_DIV    12

`endif

// [rtl/dtm_prescaler.v]
`timescale 1ns/1ps
`include "dtm_map.vh"
module dtm_prescaler #(
    parameter DIV = `DTM_PRESCALE_DIV,
    parameter W   = 4
) (
    input  wire CLOCK,
    input  wire RST,
    output reg  TICK
);
    reg [W-1:0] cnt_r;

    // One-cycle enable every DIV system clocks
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            cnt_r <= {W{1'b0}};
            TICK  <= 1'b0;
        end else if (cnt_r == DIV[W-1:0] - {{(W-1){1'b0}}, 1'b1}) begin
            cnt_r <= {W{1'b0}};
            TICK  <= 1'b1;
        end else begin
            cnt_r <= cnt_r + {{(W-1){1'b0}}, 1'b1};
            TICK  <= 1'b0;
        end
    end
endmodule

// [rtl/dtm_fall_detect.v]
`timescale 1ns/1ps
module dtm_fall_detect #(
    parameter W = 2
) (
    input  wire         CLOCK,
    input  wire         RST,
    input  wire [W-1:0] SIG,
    output wire [W-1:0] FALL
);
    genvar i;
    generate
        for (i = 0; i < W; i = i + 1) begin : g_bit
            reg prev_r;
            // Reset low so a pin held low at release gives no false edge
            always @(posedge CLOCK or posedge RST) begin
                if (RST) begin
                    prev_r <= 1'b0;
                end else begin
                    prev_r <= SIG[i];
                end
            end
            assign FALL[i] = prev_r & ~SIG[i];
        end
    endgenerate
endmodule

// [rtl/dtm_top.v]
`timescale 1ns/1ps
`include "dtm_map.vh"

// Functional notes
// - Timer 1 ungated: runs whenever its run bit is set, pin ignored.
// - Timer 1 gated: runs only with pin B active and either run bit 1 or timer 0 in mode 3.
// - Pin B active level comes from its polarity bit.
// - Timer 1 internal source: clock picked by its prescaler-select bit.
// - Timer 1 counter source: counts falling edges of its count input while timer 0 is not in mode 3.
// - Mode 00 makes the timer a 13-bit counter/timer.
// - Mode 10 makes the timer an 8-bit counter/timer.
// - Timer 1 in mode 3 is inactive: no counting, no change.
// - Timer 0 ungated: runs whenever its run bit is set, pin ignored.
// - Timer 0 gated: runs only with run bit 1 and pin A active.
// - Pin A active level comes from its polarity bit.
// - Timer 0 internal source: clock picked by its prescaler-select bit.
// - Timer 0 counter source: counts falling edges of its count input.
// - Two lowest mode-register bits select timer 0 mode, same encoding.
// - Timer 0 mode 3 splits it into two independent 8-bit counters.
// - Split high byte runs on timer 1 run bit, sets timer 1 overflow.
module dtm_top (
    input  wire        CLOCK,
    input  wire        RST,
    input  wire        HSEL,
    input  wire [31:0] HADDR,
    input  wire [1:0]  HTRANS,
    input  wire        HWRITE,
    input  wire [2:0]  HSIZE,
    input  wire [31:0] HWDATA,
    input  wire        HREADY,
    output wire        HREADYOUT,
    output wire        HRESP,
    output reg  [31:0] HRDATA,
    input  wire        EXT_IRQ_PIN_A,
    input  wire        EXT_IRQ_PIN_B,
    input  wire        T0_COUNT_INPUT,
    input  wire        T1_COUNT_INPUT,
    output wire        T0_OVERFLOW,
    output wire        T1_OVERFLOW
);
    // Bus state
    reg        wr_pend_r;
    reg  [7:0] addr_r;

    // Registers
    reg  [7:0]  timer_mode_config_r;
    reg         t0_run_r;
    reg         t1_run_r;
    reg         t0_ovf_r;
    reg         t1_ovf_r;
    reg  [1:0]  pol_r;
    reg  [1:0]  presc_r;
    reg  [15:0] t0_cnt_r;
    reg  [15:0] t1_cnt_r;

    // Next values of the counting datapath
    reg  [15:0] t0_cnt_nxt;
    reg  [15:0] t1_cnt_nxt;
    reg         t0_ovf_set;
    reg         t1_ovf_set;
    reg  [16:0] t0_step;
    reg  [16:0] t1_step;

    wire        presc_tick;
    wire [1:0]  count_fall;

    // Address match, used by both the write and the read decode
    function addr_is;
        input [7:0] a;
        input [7:0] off;
        begin
            addr_is = (a[7:2] == off[7:2]);
        end
    endfunction

    // Run qualification from run bit, gating bit and pin state
    function run_gate;
        input tr;
        input gate;
        input pin_act;
        begin
            run_gate = tr & (~gate | pin_act);
        end
    endfunction

    // One count step of a 16-bit timer; bit 16 flags overflow
    function [16:0] cnt_step;
        input [1:0]  mode;
        input [15:0] v;
        begin
            case (mode)
                `DTM_MODE_13BIT: begin
                    // Low five bits prescale the high byte
                    if (v[4:0] == 5'h1f) begin
                        cnt_step = {(v[15:8] == 8'hff), v[15:8] + 8'h01, v[7:5], 5'h00};
                    end else begin
                        cnt_step = {1'b0, v[15:5], v[4:0] + 5'h01};
                    end
                end
                `DTM_MODE_16BIT: begin
                    cnt_step = {(v == 16'hffff), v + 16'h0001};
                end
                `DTM_MODE_8BIT: begin
                    // Low byte reloads from the high byte on overflow
                    if (v[7:0] == 8'hff) begin
                        cnt_step = {1'b1, v[15:8], v[15:8]};
                    end else begin
                        cnt_step = {1'b0, v[15:8], v[7:0] + 8'h01};
                    end
                end
                default: begin
                    cnt_step = {1'b0, v};
                end
            endcase
        end
    endfunction

    dtm_prescaler #(
        .DIV (`DTM_PRESCALE_DIV),
        .W   (4)
    ) u_presc (
        .CLOCK (CLOCK),
        .RST   (RST),
        .TICK  (presc_tick)
    );

    dtm_fall_detect #(
        .W (2)
    ) u_fall (
        .CLOCK (CLOCK),
        .RST   (RST),
        .SIG   ({T1_COUNT_INPUT, T0_COUNT_INPUT}),
        .FALL  (count_fall)
    );

    // Decoded configuration fields
    wire [1:0] t0_mode   = timer_mode_config_r[`DTM_T0_MODE_HI:`DTM_T0_MODE_LO];
    wire [1:0] t1_mode   = timer_mode_config_r[`DTM_T1_MODE_HI:`DTM_T1_MODE_LO];
    wire       t0_gate   = timer_mode_config_r[`DTM_T0_GATE];
    wire       t1_gate   = timer_mode_config_r[`DTM_T1_GATE];
    wire       t0_src    = timer_mode_config_r[`DTM_T0_SRC];
    wire       t1_src    = timer_mode_config_r[`DTM_T1_SRC];
    wire       t0_split  = (t0_mode == `DTM_MODE_3);

    // Pin is active when its level equals the polarity bit
    wire       pin_a_act = (EXT_IRQ_PIN_A == pol_r[`DTM_PIN_A_POL]);
    wire       pin_b_act = (EXT_IRQ_PIN_B == pol_r[`DTM_PIN_B_POL]);

    // Internal clock: prescaler-select 1 is the system clock, 0 the divided one
    wire       t0_int_tick = presc_r[0] | presc_tick;
    wire       t1_int_tick = presc_r[1] | presc_tick;

    // Timer 0 run and count source
    wire       t0_go   = run_gate(t0_run_r, t0_gate, pin_a_act);
    wire       t0_tick = t0_src ? count_fall[0] : t0_int_tick;

    // While timer 0 is split, timer 1 loses its run bit and external source
    wire       t1_go   = run_gate(t0_split | t1_run_r, t1_gate, pin_b_act);
    wire       t1_tick = (t1_src & ~t0_split) ? count_fall[1] : t1_int_tick;

    // Split high byte: timer only, enabled by the timer 1 run bit
    wire       th0_tick = t0_split & t1_run_r & t0_int_tick;

    // Bus transfer take and register write strobes
    wire       take       = HSEL & HTRANS[1] & HREADY;
    wire       wr_mode    = wr_pend_r & addr_is(addr_r, `DTM_OFF_MODE);
    wire       wr_ctrl    = wr_pend_r & addr_is(addr_r, `DTM_OFF_CTRL);
    wire       wr_extcfg  = wr_pend_r & addr_is(addr_r, `DTM_OFF_EXTCFG);
    wire       wr_clkctl  = wr_pend_r & addr_is(addr_r, `DTM_OFF_CLKCTL);
    wire       wr_cnt0    = wr_pend_r & addr_is(addr_r, `DTM_OFF_CNT0);
    wire       wr_cnt1    = wr_pend_r & addr_is(addr_r, `DTM_OFF_CNT1);

    // Zero wait states, never an error
    assign HREADYOUT   = 1'b1;
    assign HRESP       = 1'b0;
    assign T0_OVERFLOW = t0_ovf_r;
    assign T1_OVERFLOW = t1_ovf_r;

    // Counting datapath; a software load of a counter wins over a count step
    always @* begin
        t0_step    = cnt_step(t0_mode, t0_cnt_r);
        t1_step    = cnt_step(t1_mode, t1_cnt_r);
        t0_cnt_nxt = t0_cnt_r;
        t1_cnt_nxt = t1_cnt_r;
        t0_ovf_set = 1'b0;
        t1_ovf_set = 1'b0;
        if (t0_split) begin
            // Two independent bytes
            if (t0_go & t0_tick) begin
                t0_cnt_nxt[7:0] = t0_cnt_r[7:0] + 8'h01;
                t0_ovf_set      = (t0_cnt_r[7:0] == 8'hff);
            end
            if (th0_tick) begin
                t0_cnt_nxt[15:8] = t0_cnt_r[15:8] + 8'h01;
                t1_ovf_set       = (t0_cnt_r[15:8] == 8'hff);
            end
        end else if (t0_go & t0_tick) begin
            t0_cnt_nxt = t0_step[15:0];
            t0_ovf_set = t0_step[16];
        end
        // Timer 1 in mode 3 holds its count
        if ((t1_mode != `DTM_MODE_3) & t1_go & t1_tick) begin
            t1_cnt_nxt = t1_step[15:0];
            // Split timer 0 owns the timer 1 overflow flag
            if (!t0_split) begin
                t1_ovf_set = t1_step[16];
            end
        end
        if (wr_cnt0) begin
            t0_cnt_nxt = HWDATA[15:0];
        end
        if (wr_cnt1) begin
            t1_cnt_nxt = HWDATA[15:0];
        end
    end

    // Address phase capture
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            wr_pend_r <= 1'b0;
            addr_r    <= 8'h00;
        end else begin
            wr_pend_r <= take & HWRITE;
            if (take) begin
                addr_r <= HADDR[7:0];
            end
        end
    end

    // Read data registered at the address phase; unmapped reads give zero
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            HRDATA <= 32'h00000000;
        end else if (take & ~HWRITE) begin
            if (addr_is(HADDR[7:0], `DTM_OFF_MODE)) begin
                HRDATA <= {24'h000000, timer_mode_config_r};
            end else if (addr_is(HADDR[7:0], `DTM_OFF_CTRL)) begin
                HRDATA <= {24'h000000, t1_ovf_r, t1_run_r, t0_ovf_r, t0_run_r, 4'h0};
            end else if (addr_is(HADDR[7:0], `DTM_OFF_EXTCFG)) begin
                HRDATA <= {30'h00000000, pol_r};
            end else if (addr_is(HADDR[7:0], `DTM_OFF_CLKCTL)) begin
                HRDATA <= {27'h0000000, presc_r, 3'h0};
            end else if (addr_is(HADDR[7:0], `DTM_OFF_CNT0)) begin
                HRDATA <= {16'h0000, t0_cnt_r};
            end else if (addr_is(HADDR[7:0], `DTM_OFF_CNT1)) begin
                HRDATA <= {16'h0000, t1_cnt_r};
            end else begin
                HRDATA <= 32'h00000000;
            end
        end
    end

    // Configuration registers
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            timer_mode_config_r <= `DTM_RST_MODE;
            pol_r               <= `DTM_RST_POL;
            presc_r             <= `DTM_RST_PRESC;
            t0_run_r            <= 1'b0;
            t1_run_r            <= 1'b0;
        end else begin
            if (wr_mode) begin
                timer_mode_config_r <= HWDATA[7:0];
            end
            if (wr_extcfg) begin
                pol_r <= {HWDATA[`DTM_PIN_B_POL], HWDATA[`DTM_PIN_A_POL]};
            end
            if (wr_clkctl) begin
                presc_r <= {HWDATA[`DTM_T1_PRESC], HWDATA[`DTM_T0_PRESC]};
            end
            if (wr_ctrl) begin
                t0_run_r <= HWDATA[`DTM_T0_RUN];
                t1_run_r <= HWDATA[`DTM_T1_RUN];
            end
        end
    end

    // Overflow flags: a hardware set in the clearing cycle is kept
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            t0_ovf_r <= 1'b0;
            t1_ovf_r <= 1'b0;
        end else begin
            t0_ovf_r <= t0_ovf_set | (wr_ctrl ? HWDATA[`DTM_T0_OVF] : t0_ovf_r);
            t1_ovf_r <= t1_ovf_set | (wr_ctrl ? HWDATA[`DTM_T1_OVF] : t1_ovf_r);
        end
    end

    // Counters
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            t0_cnt_r <= `DTM_RST_CNT;
            t1_cnt_r <= `DTM_RST_CNT;
        end else begin
            t0_cnt_r <= t0_cnt_nxt;
            t1_cnt_r <= t1_cnt_nxt;
        end
    end
endmodule

// [dv/dtm_chk_asserts.sv]
`timescale 1ns/1ps
module dtm_chk (
    input logic        CLOCK,
    input logic        RST,
    input logic        HSEL,
    input logic [31:0] HADDR,
    input logic [1:0]  HTRANS,
    input logic        HWRITE,
    input logic [31:0] HWDATA,
    input logic        HREADY,
    input logic        HREADYOUT,
    input logic        HRESP,
    input logic [31:0] HRDATA,
    input logic        EXT_IRQ_PIN_A,
    input logic        EXT_IRQ_PIN_B,
    input logic        T0_OVERFLOW,
    input logic        T1_OVERFLOW
);
    logic       a_wr_r;
    logic       a_rd_r;
    logic [7:0] a_off_r;
    logic [7:0] mode_r;
    logic [7:0] ctrl_r;
    logic [1:0] pol_r;
    logic [5:0] h0_r;
    logic [5:0] h1_r;
    // Enable terms, widened to a short history; a flag rises at the same edge as its count step, one cycle after the enable
    wire take = HSEL && HTRANS[1] && HREADY;
    wire wc   = a_wr_r && (a_off_r == 8'h04);
    wire [1:0] runs = {ctrl_r[6], ctrl_r[4]};
    wire ok0  = wc || (ctrl_r[4] && (!mode_r[3] || EXT_IRQ_PIN_A == pol_r[0]));
    wire ok1  = wc || ((mode_r[1:0] == 2'h3) ? ctrl_r[6] : (ctrl_r[6] && mode_r[5:4] != 2'h3
                && (!mode_r[7] || EXT_IRQ_PIN_B == pol_r[1])));
    // Shadow of what software wrote
    always @(posedge CLOCK or posedge RST) begin
        if (RST) begin
            a_wr_r <= 1'b0;
            a_rd_r <= 1'b0;
            a_off_r <= 8'h00;
            mode_r <= 8'h00;
            ctrl_r <= 8'h00;
            pol_r <= 2'h0;
            h0_r <= 6'h00;
            h1_r <= 6'h00;
        end else begin
            a_wr_r <= take && HWRITE;
            a_rd_r <= take && !HWRITE;
            if (take) a_off_r <= HADDR[7:0];
            h0_r <= {h0_r[4:0], ok0};
            h1_r <= {h1_r[4:0], ok1};
            if (a_wr_r && a_off_r == 8'h00) mode_r <= HWDATA[7:0];
            if (wc) ctrl_r <= HWDATA[7:0];
            if (a_wr_r && a_off_r == 8'h08) pol_r <= HWDATA[1:0];
        end
    end
    AST_BUS_OK: assert property (@(posedge CLOCK) disable iff (RST) HREADYOUT && !HRESP)
        else $error("bus not ready or error");
    AST_RD_HOLD: assert property (@(posedge CLOCK) disable iff (RST) !a_rd_r |-> $stable(HRDATA))
        else $error("read data moved without a read");
    AST_MODE_RB: assert property (@(posedge CLOCK) disable iff (RST)
        a_rd_r && a_off_r == 8'h00 |-> HRDATA == {24'h0, $past(mode_r)}) else $error("mode readback wrong");
    AST_RUN_RB: assert property (@(posedge CLOCK) disable iff (RST)
        a_rd_r && a_off_r == 8'h04 |-> {HRDATA[6], HRDATA[4]} == $past(runs)) else $error("run readback wrong");
    AST_T0_EN: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(T0_OVERFLOW) |-> |h0_r) else $error("timer 0 flag without enable");
    AST_T1_EN: assert property (@(posedge CLOCK) disable iff (RST)
        $rose(T1_OVERFLOW) |-> |h1_r) else $error("timer 1 flag without enable");
    AST_F0_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(T0_OVERFLOW) |-> $past(wc)) else $error("timer 0 flag dropped alone");
    AST_F1_HOLD: assert property (@(posedge CLOCK) disable iff (RST)
        $fell(T1_OVERFLOW) |-> $past(wc)) else $error("timer 1 flag dropped alone");
endmodule

bind dtm_top dtm_chk u_dtm_chk (.CLOCK(CLOCK), .RST(RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
    .HWRITE(HWRITE), .HWDATA(HWDATA), .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .HRDATA(HRDATA), .EXT_IRQ_PIN_A(EXT_IRQ_PIN_A), .EXT_IRQ_PIN_B(EXT_IRQ_PIN_B),
    .T0_OVERFLOW(T0_OVERFLOW), .T1_OVERFLOW(T1_OVERFLOW));

// [dv/dtm_tb.sv]
`timescale 1ns/1ps
`include "dtm_map.vh"
module testbench;
    logic        clock, rst, hsel, hwrite;
    logic [31:0] haddr, hwdata, d, e;
    logic [1:0]  htrans, pin, cin;
    logic [2:0]  hsize;
    logic [7:0]  a, g;
    wire         hreadyout, hresp, t0_ovf, t1_ovf;
    wire  [31:0] hrdata;
    int          err_total, n_checks, t, p, i;
    dtm_top u_dtm_top (.CLOCK(clock), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
        .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout), .HREADYOUT(hreadyout),
        .HRESP(hresp), .HRDATA(hrdata), .EXT_IRQ_PIN_A(pin[0]), .EXT_IRQ_PIN_B(pin[1]),
        .T0_COUNT_INPUT(cin[0]), .T1_COUNT_INPUT(cin[1]), .T0_OVERFLOW(t0_ovf), .T1_OVERFLOW(t1_ovf));
    // Free running 25 MHz clock
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    task chk(input string nm, input logic [31:0] s, input logic [31:0] x);
        n_checks++;
        if (s !== x) begin
            err_total++;
            $display("[ERR] %s expected %h seen %h", nm, x, s);
        end
    endtask
    // One single word transfer; an idle cycle always precedes the address phase
    task bus(input logic w, input logic [7:0] ad, input logic [31:0] wd);
        @(posedge clock);
        hsel <= 1'b1;
        haddr <= {24'h0, ad};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge clock); while (hreadyout !== 1'b1);
        d = hrdata;
    endtask
    // Falling edges spaced wider than the edge detector needs
    task fall(input int k, input int n);
        repeat (n) begin
            @(posedge clock);
            cin[k] <= 1'b0;
            repeat (2) @(posedge clock);
            cin[k] <= 1'b1;
            repeat (2) @(posedge clock);
        end
    endtask
    // Gate pin change, then a few quiet cycles before the next step
    task pn(input int k, input logic v);
        @(posedge clock);
        pin[k] <= v;
        repeat (4) @(posedge clock);
    endtask
    task t_reset;
        for (i = 0; i < 7; i++) begin
            bus(0, (i < 6) ? 8'(i * 4) : 8'h40, 0);
            chk("reset value", d, 0);
        end
        $display("reset test done");
    endtask
    task t_modes;
        for (i = 0; i < 4; i++) begin
            bus(1, `DTM_OFF_MODE, 32'(i) * 32'h55);
            bus(0, `DTM_OFF_MODE, 0);
            chk("mode field", d, 32'(i) * 32'h55);
        end
        $display("mode test done");
    endtask
    task t_ext0;
        logic [15:0] st, ex;
        for (i = 0; i < 3; i++) begin
            // Start one step short of a carry into the high byte; only the 8-bit mode rolls over
            st = (i == 0) ? 16'h001f : ((i == 1) ? 16'h00ff : 16'h80ff);
            ex = (i == 2) ? 16'h8080 : 16'h0100;
            bus(1, `DTM_OFF_CTRL, 0);
            bus(1, `DTM_OFF_MODE, 32'(i) | 32'h04);
            bus(1, `DTM_OFF_CNT0, {16'h0, st});
            bus(1, `DTM_OFF_CTRL, 32'h10);
            fall(0, 1);
            bus(0, `DTM_OFF_CNT0, 0);
            chk("count width", d, {16'h0, ex});
            chk("reload flag", {31'h0, t0_ovf}, 32'(i == 2));
        end
        $display("width test done");
    endtask
    task t_gating;
        for (t = 0; t < 2; t++) begin
            a = t ? `DTM_OFF_CNT1 : `DTM_OFF_CNT0;
            g = t ? 8'hd0 : 8'h0d;
            bus(1, `DTM_OFF_CTRL, 0);
            bus(1, a, 0);
            bus(1, `DTM_OFF_MODE, {24'h0, g});
            bus(1, `DTM_OFF_EXTCFG, 32'(1 << t));
            pn(t, 1'b0);
            bus(1, `DTM_OFF_CTRL, t ? 32'h40 : 32'h10);
            fall(t, 2);
            bus(0, a, 0);
            chk("gate closed", d, 0);
            pn(t, 1'b1);
            fall(t, 2);
            bus(0, a, 0);
            chk("gate open", d, 2);
            bus(1, `DTM_OFF_MODE, {24'h0, g & 8'h77});
            pn(t, 1'b0);
            fall(t, 2);
            bus(0, a, 0);
            chk("ungated", d, 4);
            bus(1, `DTM_OFF_MODE, {24'h0, g});
            bus(1, `DTM_OFF_EXTCFG, 0);
            fall(t, 2);
            bus(0, a, 0);
            chk("active low", d, 6);
        end
        $display("gating test done");
    endtask
    // Two reads 3 cycles apart, or 24 apart with the divided clock
    task t_int;
        for (t = 0; t < 2; t++) for (p = 0; p < 2; p++) begin
            a = t ? `DTM_OFF_CNT1 : `DTM_OFF_CNT0;
            bus(1, `DTM_OFF_CTRL, 0);
            bus(1, `DTM_OFF_CLKCTL, 32'(p) << (3 + t));
            bus(1, `DTM_OFF_MODE, t ? 32'h10 : 32'h01);
            bus(1, `DTM_OFF_CTRL, t ? 32'h40 : 32'h10);
            bus(0, a, 0);
            e = d;
            repeat (p ? 0 : 21) @(posedge clock);
            bus(0, a, 0);
            chk("internal rate", d - e, p ? 3 : 2);
        end
        $display("internal clock test done");
    endtask
    task t_t1m3;
        bus(1, `DTM_OFF_CTRL, 0);
        bus(1, `DTM_OFF_CLKCTL, 32'h10);
        bus(1, `DTM_OFF_MODE, 32'h30);
        bus(1, `DTM_OFF_CTRL, 32'h40);
        bus(0, `DTM_OFF_CNT1, 0);
        e = d;
        repeat (8) @(posedge clock);
        bus(0, `DTM_OFF_CNT1, 0);
        chk("t1 held", d, e);
        chk("t1 flag", {31'h0, t1_ovf}, 0);
        $display("timer 1 inactive test done");
    endtask
    task t_split;
        bus(1, `DTM_OFF_CTRL, 0);
        // Timer 1 rolls over at full rate while split, so a leaked flag would show
        bus(1, `DTM_OFF_CLKCTL, 32'h18);
        bus(1, `DTM_OFF_MODE, 32'h13);
        bus(1, `DTM_OFF_CNT1, 32'hffff);
        bus(1, `DTM_OFF_CNT0, 32'h10fe);
        bus(1, `DTM_OFF_CTRL, 32'h10);
        repeat (4) @(posedge clock);
        chk("low byte flag", {31'h0, t0_ovf}, 1);
        chk("t1 flag quiet", {31'h0, t1_ovf}, 0);
        bus(1, `DTM_OFF_CTRL, 0);
        bus(0, `DTM_OFF_CNT0, 0);
        chk("high byte idle", {24'h0, d[15:8]}, 32'h10);
        bus(1, `DTM_OFF_CNT0, 32'hff10);
        bus(1, `DTM_OFF_CTRL, 32'h40);
        repeat (4) @(posedge clock);
        bus(0, `DTM_OFF_CTRL, 0);
        chk("high byte flag", {29'h0, d[7:5]}, 32'h6);
        bus(0, `DTM_OFF_CNT0, 0);
        chk("low byte idle", {24'h0, d[7:0]}, 32'h10);
        $display("split test done");
    endtask
    task give_verdict;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // Main sequence
    initial begin
        rst = 1'b1;
        {hsel, hwrite, htrans, haddr, hwdata, pin} = '0;
        hsize = 3'h2;
        cin = 2'h3;
        err_total = 0;
        n_checks = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_reset;
        t_modes;
        t_ext0;
        t_gating;
        t_int;
        t_t1m3;
        t_split;
        give_verdict;
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clock);
        err_total++;
        give_verdict;
    end
endmodule
